/* File: svr_host_model.sv */
// Host processor and RAM side of the supply supervisor.
// Assumes the bench drives its requests at the rising clock edge.
`timescale 1ns/1ps

module svr_host_model (
  // Clock
  input wire logic i_clk,
  // Bench requests
  input wire logic i_kick_en,
  input wire logic i_loop,
  input wire logic i_mr_req_n,
  input wire logic i_ce_req_n,
  input wire logic i_pfo_req_n,
  // From the supervisor
  input wire logic i_wdo_n,
  // To the supervisor
  output logic o_kick,
  output logic o_mr_n,
  output logic o_ce_n,
  output logic o_pfo_n
);
  logic [5:0] ph_q = 6'h00;

  // Outputs settle at the first edge, well inside the supervisor's power-on reset
  always @(posedge i_clk) begin
    ph_q <= (!i_kick_en || ph_q == 6'h27) ? 6'h00 : ph_q + 6'h01;
    // Only the shortest legal pulse, so a missed short kick shows up
    o_kick <= i_kick_en && ph_q < 6'h05;
    // Fault output wired onto manual reset; one flop stands for the diode delay
    o_mr_n <= i_mr_req_n & (i_wdo_n | ~i_loop);
  end

  assign o_ce_n = i_ce_req_n;
  assign o_pfo_n = i_pfo_req_n;
endmodule : svr_host_model

/* File: svr_sync.sv */
// Shared constants and types of the supply supervisor core, and its input synchroniser.
// Assumes one free-running 50 MHz clock and an asynchronous active-low power-on reset.
package svr_pkg;

  // ********************************
  // Clock and timing
  // ********************************
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int RST_HOLD_MS = 200;
  localparam int RST_HOLD_CYC = (CLK_FREQ_HZ / 1000) * RST_HOLD_MS;
  localparam int WD_TIMEOUT_MS = 1600;
  localparam int WD_TIMEOUT_CYC = (CLK_FREQ_HZ / 1000) * WD_TIMEOUT_MS;
  localparam int CE_HOLD_US = 10;
  localparam int CE_HOLD_CYC = (CLK_FREQ_HZ / 1_000_000) * CE_HOLD_US;
  localparam int KICK_MIN_NS = 100;
  localparam int KICK_MIN_CYC = (KICK_MIN_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

  // ********************************
  // Counter widths
  // ********************************
  localparam int RST_CNT_W = 24;
  localparam int WD_CNT_W = 27;
  localparam int AGE_CNT_W = 10;

  // ********************************
  // Synchroniser lanes and their reset values
  // ********************************
  localparam int SYNC_W = 6;
  localparam int LANE_BELOW_RST = 0;
  localparam int LANE_BELOW_SW = 1;
  localparam int LANE_BACKUP_BATTERY_LOW = 2;
  localparam int LANE_MR_N = 3;
  localparam int LANE_KICK = 4;
  localparam int LANE_PFO_N = 5;
  // Supply assumed low, inputs idle, until the first samples arrive
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 6'h2B;

  // ********************************
  // Reset sequencer states
  // ********************************
  typedef enum logic [1:0] {
    SVR_FAULT = 2'b00,
    SVR_STRETCH = 2'b01,
    SVR_RUN = 2'b11
  } svr_state_t;

endpackage : svr_pkg

`timescale 1ns/1ps

module svr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      logic meta_q;
      logic sync_q;
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          meta_q <= RST_VAL[g];
          sync_q <= RST_VAL[g];
        end else begin
          meta_q <= i_d[g];
          sync_q <= meta_q;
        end
      end
      assign o_q[g] = sync_q;
    end
  endgenerate

endmodule : svr_sync

/* File: svr_top.sv */
// Digital core of a supply supervisor: reset stretch, watchdog, freshness seal,
// battery status and chip-enable gating.
// Assumes comparator results arrive as logic levels; the open-drain reset pin is
// resolved outside from o_reset_out_n_o and o_reset_out_n_oe.

`timescale 1ns/1ps

module svr_top #(
  parameter logic [svr_pkg::RST_CNT_W-1:0] P_RST_HOLD_CYC = svr_pkg::RST_HOLD_CYC[svr_pkg::RST_CNT_W-1:0],
  parameter logic [svr_pkg::WD_CNT_W-1:0] P_WD_TIMEOUT_CYC = svr_pkg::WD_TIMEOUT_CYC[svr_pkg::WD_CNT_W-1:0]
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Comparator results
  input wire logic i_below_reset_threshold,
  input wire logic i_below_switchover_threshold,
  input wire logic i_battery_low,
  // Host-side control inputs
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick_in,
  input wire logic i_power_fail_out_n,
  input wire logic i_chip_enable_in_n,
  // Reset outputs
  output logic o_reset_out_n_o,
  output logic o_reset_out_n_oe,
  output logic o_reset_out,
  // Status outputs
  output logic o_watchdog_fault_out_n,
  output logic o_battery_good,
  output logic o_seal_engaged,
  // RAM chip enable
  output logic o_chip_enable_out_n
);

  // ********************************
  // Input synchronisation
  // ********************************
  logic [svr_pkg::SYNC_W-1:0] raw;
  logic [svr_pkg::SYNC_W-1:0] syn;
  logic below_rst_s;
  logic below_sw_s;
  logic backup_battery_low_s;
  logic mr_n_s;
  logic kick_s;
  logic pfo_n_s;

  assign raw = {i_power_fail_out_n, i_watchdog_kick_in, i_manual_reset_n,
                i_battery_low, i_below_switchover_threshold, i_below_reset_threshold};

  svr_sync #(
    .W(svr_pkg::SYNC_W),
    .RST_VAL(svr_pkg::SYNC_RST_VAL)
  ) u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(raw),
    .o_q(syn)
  );

  assign below_rst_s = syn[svr_pkg::LANE_BELOW_RST];
  assign below_sw_s = syn[svr_pkg::LANE_BELOW_SW];
  assign backup_battery_low_s = syn[svr_pkg::LANE_BACKUP_BATTERY_LOW];
  assign mr_n_s = syn[svr_pkg::LANE_MR_N];
  assign kick_s = syn[svr_pkg::LANE_KICK];
  assign pfo_n_s = syn[svr_pkg::LANE_PFO_N];

  // ********************************
  // Reset sequencer
  // ********************************
  svr_pkg::svr_state_t state_q;
  svr_pkg::svr_state_t state_d;
  logic [svr_pkg::RST_CNT_W-1:0] hold_cnt_q;
  logic [svr_pkg::RST_CNT_W-1:0] hold_cnt_d;
  logic first_half;
  logic mr_act;
  logic rst_cause;
  logic rst_now;
  logic rst_d;

  // First half of the stretch; the fault phase counts as its start
  assign first_half = (state_q != svr_pkg::SVR_RUN) && (hold_cnt_q < (P_RST_HOLD_CYC >> 1));
  // Forcing the fail output low lets the seal be set up without a manual reset loop interfering
  assign mr_act = !mr_n_s && !(first_half && !pfo_n_s);
  assign rst_cause = below_rst_s || below_sw_s || mr_act;
  assign rst_now = (state_q != svr_pkg::SVR_RUN);
  assign rst_d = (state_d != svr_pkg::SVR_RUN);

  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    if (rst_cause) begin
      state_d = svr_pkg::SVR_FAULT;
      hold_cnt_d = '0;
    end else begin
      case (state_q)
        svr_pkg::SVR_FAULT: begin
          state_d = svr_pkg::SVR_STRETCH;
          hold_cnt_d = '0;
        end
        svr_pkg::SVR_STRETCH: begin
          if (hold_cnt_q == P_RST_HOLD_CYC - 1'b1) begin
            state_d = svr_pkg::SVR_RUN;
            hold_cnt_d = '0;
          end else begin
            hold_cnt_d = hold_cnt_q + 1'b1;
          end
        end
        svr_pkg::SVR_RUN: begin
          hold_cnt_d = '0;
        end
        default: begin
          state_d = svr_pkg::SVR_FAULT;
          hold_cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= svr_pkg::SVR_FAULT;
      hold_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // Open-drain pin only ever pulls low, so the data side stays at zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reset_out_n_o <= 1'b0;
      o_reset_out_n_oe <= 1'b1;
      o_reset_out <= 1'b1;
    end else begin
      o_reset_out_n_o <= 1'b0;
      o_reset_out_n_oe <= rst_d;
      o_reset_out <= rst_d;
    end
  end

  // ********************************
  // Time since reset assertion
  // ********************************
  logic [svr_pkg::AGE_CNT_W-1:0] age_q;
  logic age_done;

  assign age_done = (age_q == svr_pkg::CE_HOLD_CYC[svr_pkg::AGE_CNT_W-1:0]);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      age_q <= '0;
    end else if (!rst_now) begin
      age_q <= '0;
    end else if (!age_done) begin
      age_q <= age_q + 1'b1;
    end
  end

  // ********************************
  // Freshness seal
  // ********************************
  logic pwrup_q;
  logic pfo_low_q;
  logic armed_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwrup_q <= 1'b1;
      pfo_low_q <= 1'b1;
    end else if (!rst_now && rst_d) begin
      pwrup_q <= below_rst_s;
      pfo_low_q <= !pfo_n_s;
    end else if (rst_now) begin
      if (below_rst_s) begin
        pwrup_q <= 1'b1;
      end
      if (pfo_n_s) begin
        pfo_low_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed_q <= 1'b0;
      o_seal_engaged <= 1'b0;
    end else begin
      if (rst_now && !rst_d) begin
        armed_q <= pwrup_q && pfo_low_q && !pfo_n_s;
      end else if (armed_q && below_rst_s) begin
        armed_q <= 1'b0;
      end
      if (armed_q && below_rst_s) begin
        o_seal_engaged <= 1'b1;
      end else if (o_seal_engaged && !below_rst_s) begin
        o_seal_engaged <= 1'b0;
      end
    end
  end

  // ********************************
  // Battery status
  // ********************************
  logic backup_battery_good_raw;

  assign backup_battery_good_raw = !backup_battery_low_s;

  // During reset the last reading is kept rather than trusted afresh
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_battery_good <= 1'b0;
    end else if (below_sw_s) begin
      o_battery_good <= 1'b0;
    end else if (!rst_now) begin
      o_battery_good <= backup_battery_good_raw;
    end
  end

  // ********************************
  // Watchdog
  // ********************************
  // A 100 ns kick spans KICK_MIN_CYC clock periods, so the sampled level always sees it
  logic kick_prev_q;
  logic kick_edge;
  logic [svr_pkg::WD_CNT_W-1:0] wd_cnt_q;
  logic wd_expire;

  assign kick_edge = kick_s ^ kick_prev_q;
  assign wd_expire = (wd_cnt_q == P_WD_TIMEOUT_CYC - 1'b1);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      kick_prev_q <= 1'b0;
    end else begin
      kick_prev_q <= kick_s;
    end
  end

  // No enable input exists, so the watchdog can never be switched off
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wd_cnt_q <= '0;
    end else if (rst_now || kick_edge) begin
      wd_cnt_q <= '0;
    end else if (!wd_expire) begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // Low stays for 10 us into a reset so a looped manual reset gets a visible pulse
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_watchdog_fault_out_n <= 1'b0;
    end else if (below_sw_s) begin
      o_watchdog_fault_out_n <= 1'b0;
    end else if (kick_edge) begin
      o_watchdog_fault_out_n <= 1'b1;
    end else if (rst_now) begin
      if (age_done) begin
        o_watchdog_fault_out_n <= 1'b1;
      end
    end else if (wd_expire) begin
      o_watchdog_fault_out_n <= 1'b0;
    end
  end

  // ********************************
  // Chip-enable gate
  // ********************************
  logic ce_hold_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ce_hold_q <= 1'b0;
    end else if (!rst_now && rst_d) begin
      ce_hold_q <= !i_chip_enable_in_n;
    end else if (i_chip_enable_in_n || age_done || !rst_d) begin
      ce_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chip_enable_out_n <= 1'b1;
    end else if (!rst_d) begin
      o_chip_enable_out_n <= i_chip_enable_in_n;
    end else if ((!rst_now || ce_hold_q) && !i_chip_enable_in_n && !age_done) begin
      o_chip_enable_out_n <= 1'b0;
    end else begin
      o_chip_enable_out_n <= 1'b1;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  property p_mr_reset;
    @(posedge i_clk) disable iff (!i_arst_n) mr_act |=> o_reset_out_n_oe && hold_cnt_q == 0;
  endproperty
  a_mr_reset: assert property (p_mr_reset) else $error("manual reset did not assert reset");

  property p_mr_ignored;
    @(posedge i_clk) disable iff (!i_arst_n)
      (state_q == svr_pkg::SVR_STRETCH && first_half && !pfo_n_s && !below_rst_s && !below_sw_s)
      |=> state_q != svr_pkg::SVR_FAULT;
  endproperty
  a_mr_ignored: assert property (p_mr_ignored) else $error("manual reset not ignored in seal window");

  property p_restart;
    @(posedge i_clk) disable iff (!i_arst_n) below_rst_s |=> o_reset_out_n_oe && hold_cnt_q == 0;
  endproperty
  a_restart: assert property (p_restart) else $error("brownout did not restart reset timer");

  property p_full_hold;
    @(posedge i_clk) disable iff (!i_arst_n) $fell(o_reset_out_n_oe) |-> $past(hold_cnt_q) == P_RST_HOLD_CYC - 1'b1;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("reset released before full hold period");

  property p_inverse;
    @(posedge i_clk) disable iff (!i_arst_n) o_reset_out == (o_reset_out_n_oe && !o_reset_out_n_o);
  endproperty
  a_inverse: assert property (p_inverse) else $error("active-high reset not inverse of open-drain reset");

  property p_below_sw;
    @(posedge i_clk) disable iff (!i_arst_n)
      below_sw_s |=> o_reset_out_n_oe && !o_battery_good && !o_watchdog_fault_out_n;
  endproperty
  a_below_sw: assert property (p_below_sw) else $error("switchover level not honoured");

  property p_backup_battery_follow;
    @(posedge i_clk) disable iff (!i_arst_n)
      (!rst_now && !below_sw_s) |=> o_battery_good == $past(backup_battery_good_raw);
  endproperty
  a_backup_battery_follow: assert property (p_backup_battery_follow) else $error("battery status not following comparator");

  property p_wd_timeout;
    @(posedge i_clk) disable iff (!i_arst_n)
      (wd_expire && !rst_now && !kick_edge && !below_sw_s) |=> !o_watchdog_fault_out_n;
  endproperty
  a_wd_timeout: assert property (p_wd_timeout) else $error("watchdog did not fire at timeout");

  property p_kick_clear;
    @(posedge i_clk) disable iff (!i_arst_n)
      (kick_edge && !below_sw_s) |=> o_watchdog_fault_out_n && wd_cnt_q == 0;
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("kick did not clear the watchdog");

  property p_wd_release;
    @(posedge i_clk) disable iff (!i_arst_n)
      (rst_now && age_done && !below_sw_s) |=> o_watchdog_fault_out_n;
  endproperty
  a_wd_release: assert property (p_wd_release) else $error("fault output not high 10 us into reset");

  property p_ce_follow;
    @(posedge i_clk) disable iff (!i_arst_n) (!rst_d) |=> o_chip_enable_out_n == $past(i_chip_enable_in_n);
  endproperty
  a_ce_follow: assert property (p_ce_follow) else $error("chip enable not following outside reset");

  property p_ce_block;
    @(posedge i_clk) disable iff (!i_arst_n) (rst_now && rst_d && !ce_hold_q) |=> o_chip_enable_out_n;
  endproperty
  a_ce_block: assert property (p_ce_block) else $error("chip enable passed during reset");

  property p_ce_end;
    @(posedge i_clk) disable iff (!i_arst_n) (ce_hold_q && i_chip_enable_in_n) |=> !ce_hold_q ##1 o_chip_enable_out_n;
  endproperty
  a_ce_end: assert property (p_ce_end) else $error("chip enable hold did not end");

  c_seal: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_seal_engaged));
  c_wd_fault: cover property (@(posedge i_clk) disable iff (!i_arst_n) $fell(o_watchdog_fault_out_n));
  c_release: cover property (@(posedge i_clk) disable iff (!i_arst_n) $fell(o_reset_out_n_oe));
  c_ce_hold: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(ce_hold_q));

endmodule : svr_top

/* File: svr_top_test.sv */
// Self-checking bench of the supply supervisor core.
// Assumes shortened hold and watchdog counts; chip-enable hold stays 500 cycles.
`timescale 1ns/1ps

module svr_top_test;
  localparam int HOLD = 64;
  localparam int WDT = 256;
  localparam int CEH = 500;
  logic clk = 1'h0;
  logic arst_n, below_rst, below_sw, backup_battery_low;
  logic kick_en, loop_en, mr_req_n, ce_req_n, pfo_req_n;
  logic kick, mr_n, ce_in_n, pfo_n;
  logic rst_o, rst_oe, rst, wdo_n, bat_good, seal, ce_out_n;
  int err_count = 0;
  int comparisons = 0;

  always #10 clk = ~clk;

  svr_top #(
    .P_RST_HOLD_CYC(HOLD[svr_pkg::RST_CNT_W-1:0]),
    .P_WD_TIMEOUT_CYC(WDT[svr_pkg::WD_CNT_W-1:0])
  ) dut_u (
    .i_clk(clk), .i_arst_n(arst_n),
    .i_below_reset_threshold(below_rst), .i_below_switchover_threshold(below_sw),
    .i_battery_low(backup_battery_low), .i_manual_reset_n(mr_n), .i_watchdog_kick_in(kick),
    .i_power_fail_out_n(pfo_n), .i_chip_enable_in_n(ce_in_n),
    .o_reset_out_n_o(rst_o), .o_reset_out_n_oe(rst_oe), .o_reset_out(rst),
    .o_watchdog_fault_out_n(wdo_n), .o_battery_good(bat_good),
    .o_seal_engaged(seal), .o_chip_enable_out_n(ce_out_n)
  );

  svr_host_model host_u (
    .i_clk(clk), .i_kick_en(kick_en), .i_loop(loop_en), .i_mr_req_n(mr_req_n),
    .i_ce_req_n(ce_req_n), .i_pfo_req_n(pfo_req_n), .i_wdo_n(wdo_n),
    .o_kick(kick), .o_mr_n(mr_n), .o_ce_n(ce_in_n), .o_pfo_n(pfo_n)
  );

  // ********************************
  // Shared helpers
  // ********************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // A count inside the window is its own expectation; outside, the nearer bound is
  task automatic rng(input string what, input int n, input int lo, input int hi);
    chk(what, n, (n < lo) ? lo : (n > hi) ? hi : n);
  endtask : rng

  // Edges until the chosen output shows lvl; bounded so a stuck output cannot hang
  task automatic cnt(input int which, input logic lvl, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      s = which == 0 ? rst : which == 1 ? wdo_n : which == 2 ? ce_out_n : seal;
      n++;
    end while (s !== lvl && n < 2000);
    // Running out of edges counts as a mismatch
    chk("wait_level", s, lvl);
  endtask : cnt

  task automatic summarize();
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // ********************************
  // Scenarios
  // ********************************
  task automatic power_up();
    int n;
    cyc(5);
    #1;
    chk("reset_on", rst, 1'h1);
    chk("reset_oe", rst_oe, 1'h1);
    chk("reset_data", rst_o, 1'h0);
    cyc(1);
    below_rst <= 1'h0;
    cnt(0, 1'h0, n);
    rng("power_up_hold", n, HOLD, HOLD + 8);
    chk("reset_oe_off", rst_oe, 1'h0);
  endtask : power_up

  task automatic battery();
    cyc(1);
    backup_battery_low <= 1'h1;
    cyc(4);
    #1;
    chk("backup_battery_low", bat_good, 1'h0);
    cyc(1);
    backup_battery_low <= 1'h0;
    cyc(4);
    #1;
    chk("battery_good", bat_good, 1'h1);
  endtask : battery

  task automatic manual();
    int n;
    cyc(1);
    mr_req_n <= 1'h0;
    cnt(0, 1'h1, n);
    rng("mr_assert", n, 1, 5);
    cyc(1);
    ce_req_n <= 1'h0;
    cyc(20);
    #1;
    chk("ce_blocked", ce_out_n, 1'h1);
    cyc(1);
    mr_req_n <= 1'h1;
    cyc(16);
    #1;
    chk("ce_half_hold", ce_out_n, 1'h1);
    cnt(0, 1'h0, n);
    rng("mr_stretch", n, HOLD - 16, HOLD - 6);
    cyc(2);
    #1;
    chk("ce_pass", ce_out_n, 1'h0);
  endtask : manual

  task automatic ce_hold();
    int n;
    cyc(1);
    mr_req_n <= 1'h0;
    cnt(0, 1'h1, n);
    cnt(2, 1'h1, n);
    rng("ce_hold_full", n, CEH - 5, CEH + 5);
    cyc(1);
    mr_req_n <= 1'h1;
    cnt(0, 1'h0, n);
    cyc(3);
    mr_req_n <= 1'h0;
    cnt(0, 1'h1, n);
    cyc(20);
    #1;
    chk("ce_hold_mid", ce_out_n, 1'h0);
    cyc(1);
    ce_req_n <= 1'h1;
    cnt(2, 1'h1, n);
    rng("ce_hold_cut", n, 1, 3);
    cyc(1);
    ce_req_n <= 1'h0;
    cyc(3);
    #1;
    chk("ce_reblocked", ce_out_n, 1'h1);
    cyc(1);
    mr_req_n <= 1'h1;
    ce_req_n <= 1'h1;
    cnt(0, 1'h0, n);
  endtask : ce_hold

  task automatic brownout();
    int n;
    cyc(1);
    below_rst <= 1'h1;
    cyc(4);
    #1;
    chk("brown_reset", rst, 1'h1);
    chk("seal_unarmed", seal, 1'h0);
    cyc(1);
    below_rst <= 1'h0;
    cyc(30);
    below_rst <= 1'h1;
    cyc(3);
    below_rst <= 1'h0;
    cnt(0, 1'h0, n);
    rng("brown_restart", n, HOLD, HOLD + 8);
    cyc(1);
    below_sw <= 1'h1;
    cyc(4);
    #1;
    chk("sw_reset", rst, 1'h1);
    chk("sw_backup_battery", bat_good, 1'h0);
    chk("sw_wdo", wdo_n, 1'h0);
    cyc(1);
    below_sw <= 1'h0;
    cnt(0, 1'h0, n);
    rng("sw_release", n, HOLD, HOLD + 8);
  endtask : brownout

  task automatic pfo_ignore();
    int n;
    cyc(1);
    pfo_req_n <= 1'h0;
    below_rst <= 1'h1;
    cyc(4);
    below_rst <= 1'h0;
    cyc(10);
    mr_req_n <= 1'h0;
    cyc(5);
    mr_req_n <= 1'h1;
    cnt(0, 1'h0, n);
    rng("mr_ignored", n, HOLD - 16, HOLD - 6);
  endtask : pfo_ignore

  task automatic seal_check();
    int n;
    cyc(1);
    below_rst <= 1'h1;
    cnt(3, 1'h1, n);
    rng("seal_on", n, 1, 5);
    cyc(20);
    #1;
    chk("seal_kept", seal, 1'h1);
    cyc(1);
    below_rst <= 1'h0;
    cnt(3, 1'h0, n);
    rng("seal_off", n, 1, 5);
    cnt(0, 1'h0, n);
    cyc(1);
    pfo_req_n <= 1'h1;
  endtask : seal_check

  task automatic watchdog();
    int n;
    cyc(1);
    kick_en <= 1'h0;
    mr_req_n <= 1'h0;
    cyc(3);
    mr_req_n <= 1'h1;
    cnt(0, 1'h1, n);
    cnt(0, 1'h0, n);
    cnt(1, 1'h0, n);
    rng("wd_timeout", n, WDT - 4, WDT + 6);
    cyc(1);
    kick_en <= 1'h1;
    cnt(1, 1'h1, n);
    rng("wd_kick", n, 1, 6);
    n = 0;
    repeat (3 * WDT) begin
      @(posedge clk);
      #1;
      n += (wdo_n !== 1'h1);
    end
    rng("wd_served", n, 0, 0);
  endtask : watchdog

  task automatic looped();
    int n;
    cyc(1);
    kick_en <= 1'h0;
    loop_en <= 1'h1;
    cnt(1, 1'h0, n);
    rng("loop_fault", n, 1, WDT + 6);
    cnt(0, 1'h1, n);
    rng("loop_reset", n, 1, 5);
    cnt(1, 1'h1, n);
    rng("loop_pulse", n, CEH - 5, CEH + 5);
    cnt(0, 1'h0, n);
    rng("loop_stretch", n, HOLD, HOLD + 8);
    cnt(1, 1'h0, n);
    rng("loop_period", n, WDT - 4, WDT + 6);
    cnt(1, 1'h1, n);
    cyc(1);
    loop_en <= 1'h0;
    kick_en <= 1'h1;
    cnt(0, 1'h0, n);
  endtask : looped

  // ********************************
  // Main sequence and watchdog
  // ********************************
  initial begin
    arst_n = 1'h0;
    below_rst = 1'h1;
    below_sw = 1'h0;
    backup_battery_low = 1'h0;
    kick_en = 1'h1;
    loop_en = 1'h0;
    mr_req_n = 1'h1;
    ce_req_n = 1'h1;
    pfo_req_n = 1'h1;
    cyc(20);
    arst_n <= 1'h1;
    power_up();
    battery();
    manual();
    ce_hold();
    brownout();
    pfo_ignore();
    seal_check();
    watchdog();
    looped();
    summarize();
  end

  // About ten times the expected run
  initial begin
    #(20 * 40000);
    err_count++;
    summarize();
  end
endmodule : svr_top_test
